// ==== design/cpps_pkg.sv ====
// constants, types and helpers for the serial power and pin function registers
// assumes an 8-bit index/data configuration port and a 16-bit host address bus
package cpps_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // register indices loaded into the configuration index register
  localparam logic [7:0]  IDX_SERIAL_POWER   = 8'h02;
  localparam logic [7:0]  IDX_PIN_FUNCTION   = 8'h03;

  // power-up values; the pin function value is kept as printed, the 8-bit image
  // is taken from bits 10:3 so that every documented field default holds
  localparam logic [7:0]  SERIAL_POWER_RST   = 8'h88;
  localparam logic [11:0] PIN_FUNCTION_DOC   = 12'h780;
  localparam logic [7:0]  PIN_FUNCTION_RST   = PIN_FUNCTION_DOC[10:3];

  // serial power fields
  localparam int          SP_PRIMARY_BIT     = 3;
  localparam int          SP_SECONDARY_BIT   = 7;
  localparam logic [7:0]  SP_USED_MASK       = 8'h88;

  // pin function fields
  localparam int          PF_GAME_BIT        = 0;
  localparam int          PF_ENH2_BIT        = 1;
  localparam int          PF_ALTSEL_BIT      = 2;
  localparam int          PF_DENS_BIT        = 4;
  localparam int          PF_ENC_BIT         = 5;
  localparam int          PF_IDENT_BIT       = 6;
  localparam int          PF_SHARE_BIT       = 7;
  localparam logic [7:0]  PF_USED_MASK       = 8'hf7;

  // host decode
  localparam logic [15:0] BASE_VALID_MIN     = 16'h0100;
  localparam int          SERIAL_SPAN_LOG2   = 3;

  ////////////////////////////////////////////////////////////////////////////////
  // floppy interface modes, in identity/encoding bit order
  typedef enum logic [1:0] {
    CPPS_FDD_LEGACY3,
    CPPS_FDD_COMPAT2,
    CPPS_FDD_RESERVED,
    CPPS_FDD_AT
  } cpps_fdd_mode_t;

  // a base below the threshold switches host decoding off
  function automatic logic cpps_base_valid(input logic [15:0] base);
    return base >= BASE_VALID_MIN;
  endfunction

  // register access needs configuration mode and a matching index
  function automatic logic cpps_access_ok(input logic       cfgMode,
                                          input logic [7:0] idx,
                                          input logic [7:0] target);
    return cfgMode && (idx == target);
  endfunction

endpackage

// ==== design/cpps_dec_if.sv ====
// carrier between the register block and its address range decoder
// assumes one instance per serial logical device
`timescale 1ns/1ps
interface cpps_dec_if;
  logic [15:0] base;
  logic [15:0] addr;
  logic        hit;
  logic        active;

  // register block side
  modport owner (output base, output addr, input hit, input active);
  // decoder side
  modport dec (input base, input addr, output hit, output active);
endinterface

// ==== design/cpps_decode.sv ====
// address range decoder for one serial logical device
// assumes the base comes from the device's base address register outside
`timescale 1ns/1ps
module cpps_decode (
  // clock, reset and enable
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic ce,
  // decode carrier
  cpps_dec_if.dec   dif
);
  import cpps_pkg::*;

  logic activeD;
  logic activeQ;
  logic hitD;
  logic hitQ;

  ////////////////////////////////////////////////////////////////////////////////
  // decode ignores power state; only a low base switches it off
  always_comb begin
    activeD = cpps_base_valid(dif.base);
    hitD    = activeD && (dif.addr[15:SERIAL_SPAN_LOG2] == dif.base[15:SERIAL_SPAN_LOG2]);
  end

  // registered results
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      activeQ <= 1'b0;
      hitQ    <= 1'b0;
    end else if (ce) begin
      activeQ <= activeD;
      hitQ    <= hitD;
    end
  end

  assign dif.active = activeQ;
  assign dif.hit    = hitQ;

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_low_base_nohit: assert property (ce && !cpps_base_valid(dif.base) |=> !dif.hit)
    else $error("decoder hit with a base below the threshold");
  a_valid_base_active: assert property (ce && cpps_base_valid(dif.base) |=> dif.active)
    else $error("valid base not taking part in range checking");
endmodule

// ==== design/cpps_regs.sv ====
// serial power and pin function configuration registers with their pin muxes
// assumes a configuration port (mode flag, index and data strobes) on clk,
// sys_rst is the power-up reset and hostReset the chip's hardware reset
`timescale 1ns/1ps
module cpps_regs (
  // clock, resets and enable
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  input  wire logic                 hostReset,
  input  wire logic                 ce,
  // configuration port
  input  wire logic                 cfgMode,
  input  wire logic                 idxWr,
  input  wire logic                 dataWr,
  input  wire logic                 dataRd,
  input  wire logic [7:0]           wrData,
  output logic      [7:0]           rdData,
  output logic                      rdValid,
  // host decode
  input  wire logic [15:0]          hostAddr,
  input  wire logic [15:0]          primaryBase,
  input  wire logic [15:0]          secondaryBase,
  output logic                      primaryAddrHit,
  output logic                      secondaryAddrHit,
  output logic                      primaryRangeActive,
  output logic                      secondaryRangeActive,
  // serial port power
  output logic                      primarySerialRun,
  output logic                      secondarySerialRun,
  // floppy modes
  output logic                      enhancedFloppyMode2,
  output cpps_pkg::cpps_fdd_mode_t  floppyIfMode,
  // power good / game select pin
  input  wire logic                 powerGoodInput,
  input  wire logic                 gameSelReq,
  output logic                      chipPowerGood,
  output logic                      gamePortSelectOutN,
  output logic                      gamePortSelectOeN,
  // density select pin
  input  wire logic                 densityReq,
  output logic                      densitySelectOutB,
  // shared second-drive / address / interrupt pin
  input  wire logic                 secondDrivePresentIn,
  input  wire logic                 extraAddrReq,
  input  wire logic                 auxIrqReq,
  output logic                      secondDrivePresent,
  output logic                      sharedPinOut,
  output logic                      sharedPinOeN
);
  import cpps_pkg::*;

  logic [7:0]     configIndexD;
  logic [7:0]     configIndexQ;
  logic [7:0]     serialPowerD;
  logic [7:0]     serialPowerQ;
  logic [7:0]     pinFunctionD;
  logic [7:0]     pinFunctionQ;
  logic [7:0]     rdDataD;
  logic [7:0]     rdDataQ;
  logic           rdValidD;
  logic           rdValidQ;
  logic           spAccess;
  logic           pfAccess;
  cpps_fdd_mode_t fddModeD;
  cpps_fdd_mode_t fddModeQ;
  logic [8:0]     pinD;
  logic [8:0]     pinQ;

  ////////////////////////////////////////////////////////////////////////////////
  // index register follows the hardware reset; the config registers do not
  always_comb begin
    configIndexD = configIndexQ;
    if (hostReset) begin
      configIndexD = 8'h00;
    end else if (cfgMode && idxWr) begin
      configIndexD = wrData;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      configIndexQ <= 8'h00;
    end else if (ce) begin
      configIndexQ <= configIndexD;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register writes; reserved bits are never stored
  always_comb begin
    spAccess     = cpps_access_ok(cfgMode, configIndexQ, IDX_SERIAL_POWER);
    pfAccess     = cpps_access_ok(cfgMode, configIndexQ, IDX_PIN_FUNCTION);
    serialPowerD = serialPowerQ;
    pinFunctionD = pinFunctionQ;
    if (dataWr && !idxWr && spAccess) begin
      serialPowerD = wrData & SP_USED_MASK;
    end
    if (dataWr && !idxWr && pfAccess) begin
      pinFunctionD = wrData & PF_USED_MASK;
    end
  end

  // only the power-up reset restores defaults
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      serialPowerQ <= SERIAL_POWER_RST;
      pinFunctionQ <= PIN_FUNCTION_RST;
    end else if (ce) begin
      serialPowerQ <= serialPowerD;
      pinFunctionQ <= pinFunctionD;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // reads answer one cycle later; a refused read returns zero
  always_comb begin
    rdValidD = dataRd && !idxWr;
    rdDataD  = 8'h00;
    if (dataRd && spAccess) begin
      rdDataD = serialPowerQ;
    end else if (dataRd && pfAccess) begin
      rdDataD = pinFunctionQ;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdDataQ  <= 8'h00;
      rdValidQ <= 1'b0;
    end else if (ce) begin
      rdDataQ  <= rdDataD;
      rdValidQ <= rdValidD;
    end
  end

  assign rdData  = rdDataQ;
  assign rdValid = rdValidQ;

  ////////////////////////////////////////////////////////////////////////////////
  // floppy interface mode from identity and encoding bits
  always_comb begin
    case ({pinFunctionQ[PF_IDENT_BIT], pinFunctionQ[PF_ENC_BIT]})
      2'b11:   fddModeD = CPPS_FDD_AT;
      2'b10:   fddModeD = CPPS_FDD_RESERVED;
      2'b01:   fddModeD = CPPS_FDD_COMPAT2;
      2'b00:   fddModeD = CPPS_FDD_LEGACY3;
      default: fddModeD = CPPS_FDD_AT;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fddModeQ <= CPPS_FDD_AT;
    end else if (ce) begin
      fddModeQ <= fddModeD;
    end
  end

  assign floppyIfMode = fddModeQ;

  ////////////////////////////////////////////////////////////////////////////////
  // pin and enable muxes, packed as
  // {priRun, secRun, enh2, pwrGood, gameN, gameOeN, dens, second_drive_present_in, shared}
  // shared pin enable is kept apart below through sharedOeN
  logic sharedOeND;
  logic sharedOeNQ;

  always_comb begin
    pinD[8] = serialPowerQ[SP_PRIMARY_BIT];
    pinD[7] = serialPowerQ[SP_SECONDARY_BIT];
    pinD[6] = pinFunctionQ[PF_ENH2_BIT];
    // shared power-good / game select pin
    if (pinFunctionQ[PF_GAME_BIT]) begin
      pinD[5] = 1'b1;
      pinD[4] = ~gameSelReq;
      pinD[3] = 1'b0;
    end else begin
      pinD[5] = powerGoodInput;
      pinD[4] = 1'b1;
      pinD[3] = 1'b1;
    end
    pinD[2] = pinFunctionQ[PF_DENS_BIT] ? 1'b1 : densityReq;
    // shared second-drive / address / interrupt pin
    if (!pinFunctionQ[PF_SHARE_BIT]) begin
      pinD[1]    = secondDrivePresentIn;
      pinD[0]    = 1'b0;
      sharedOeND = 1'b1;
    end else begin
      pinD[1]    = 1'b0;
      pinD[0]    = pinFunctionQ[PF_ALTSEL_BIT] ? auxIrqReq : extraAddrReq;
      sharedOeND = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pinQ       <= 9'h1bc;
      sharedOeNQ <= 1'b0;
    end else if (ce) begin
      pinQ       <= pinD;
      sharedOeNQ <= sharedOeND;
    end
  end

  assign primarySerialRun   = pinQ[8];
  assign secondarySerialRun = pinQ[7];
  assign enhancedFloppyMode2 = pinQ[6];
  assign chipPowerGood      = pinQ[5];
  assign gamePortSelectOutN = pinQ[4];
  assign gamePortSelectOeN  = pinQ[3];
  assign densitySelectOutB  = pinQ[2];
  assign secondDrivePresent = pinQ[1];
  assign sharedPinOut       = pinQ[0];
  assign sharedPinOeN       = sharedOeNQ;

  ////////////////////////////////////////////////////////////////////////////////
  // address decoders run regardless of serial power state
  cpps_dec_if priDif ();
  cpps_dec_if secDif ();

  assign priDif.base = primaryBase;
  assign priDif.addr = hostAddr;
  assign secDif.base = secondaryBase;
  assign secDif.addr = hostAddr;

  cpps_decode uPriDec (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .dif     (priDif)
  );

  cpps_decode uSecDec (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .dif     (secDif)
  );

  assign primaryAddrHit       = priDif.hit;
  assign secondaryAddrHit     = secDif.hit;
  assign primaryRangeActive   = priDif.active;
  assign secondaryRangeActive = secDif.active;

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_sp_write;
    ce && dataWr && !idxWr && cfgMode && configIndexQ == IDX_SERIAL_POWER;
  endsequence

  sequence s_pf_write;
    ce && dataWr && !idxWr && cfgMode && configIndexQ == IDX_PIN_FUNCTION;
  endsequence

  a_sp_write_takes: assert property (s_sp_write |=> serialPowerQ == ($past(wrData) & 8'h88))
    else $error("serial power write not stored");
  a_sp_no_stray: assert property ((ce && !(dataWr && spAccess && !idxWr))
                                  |=> $stable(serialPowerQ))
    else $error("serial power changed without a permitted write");
  a_pf_write_takes: assert property (s_pf_write |=> pinFunctionQ == ($past(wrData) & 8'hf7))
    else $error("pin function write not stored");
  a_pf_no_stray: assert property ((ce && !(dataWr && pfAccess && !idxWr))
                                  |=> $stable(pinFunctionQ))
    else $error("pin function changed without a permitted write");
  a_power_up_value: assert property ($fell(sys_rst) |-> serialPowerQ == 8'h88
                                     && pinFunctionQ == 8'hf0)
    else $error("wrong power-up value");
  a_hwrst_keeps: assert property (ce && hostReset && !dataWr |=> $stable(serialPowerQ)
                                  && $stable(pinFunctionQ))
    else $error("hardware reset disturbed config registers");
  a_primary_run: assert property (ce |=> primarySerialRun == $past(serialPowerQ[3]))
    else $error("primary serial run does not follow bit 3");
  a_secondary_run: assert property (ce |=> secondarySerialRun == $past(serialPowerQ[7]))
    else $error("secondary serial run does not follow bit 7");
  a_density_high: assert property (ce && pinFunctionQ[4] |=> densitySelectOutB)
    else $error("density pin not held high");
  a_shared_input: assert property (ce && !pinFunctionQ[7] |=> sharedPinOeN
                                   && secondDrivePresent == $past(secondDrivePresentIn))
    else $error("shared pin not an input while bit 7 clear");
  a_game_select: assert property (ce && pinFunctionQ[0] |=> !gamePortSelectOeN
                                  && gamePortSelectOutN == !$past(gameSelReq))
    else $error("game select pin not driven");
  a_fdd_mode_map: assert property (ce && pinFunctionQ[6:5] == 2'b01
                                   |=> floppyIfMode == CPPS_FDD_COMPAT2)
    else $error("floppy interface mode decode wrong");
  a_enh_mode: assert property (ce |=> enhancedFloppyMode2 == $past(pinFunctionQ[1]))
    else $error("enhanced floppy mode does not follow bit 1");
  a_decode_unpowered: assert property (ce && !serialPowerQ[3] && cpps_base_valid(primaryBase)
                                       |=> primaryRangeActive)
    else $error("powered-down device dropped its decode");
endmodule

// ==== bench/cpps_regs_tb.sv ====
// self-checking bench for the serial power and pin function registers
// assumes cpps_pkg and cpps_regs compiled first; inputs change at the falling edge
`timescale 1ns/1ps
module cpps_regs_tb;
  import cpps_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // stimulus and observed signals
  logic           clk, sysRst, hostReset, ce, cfgMode, idxWr, dataWr, dataRd;
  logic [7:0]     wrData, rdData;
  logic           rdValid, primaryAddrHit, secondaryAddrHit;
  logic           primaryRangeActive, secondaryRangeActive;
  logic [15:0]    hostAddr, primaryBase, secondaryBase;
  logic           primarySerialRun, secondarySerialRun, enhancedFloppyMode2;
  cpps_fdd_mode_t floppyIfMode;
  logic           powerGoodInput, gameSelReq, chipPowerGood;
  logic           gamePortSelectOutN, gamePortSelectOeN, densityReq, densitySelectOutB;
  logic           secondDrivePresentIn, extraAddrReq, auxIrqReq;
  logic           secondDrivePresent, sharedPinOut, sharedPinOeN;
  int             numErrors, nCompared;

  cpps_regs i_dut (
    .clk(clk), .sys_rst(sysRst), .hostReset(hostReset), .ce(ce), .cfgMode(cfgMode),
    .idxWr(idxWr), .dataWr(dataWr), .dataRd(dataRd), .wrData(wrData), .rdData(rdData),
    .rdValid(rdValid), .hostAddr(hostAddr), .primaryBase(primaryBase),
    .secondaryBase(secondaryBase), .primaryAddrHit(primaryAddrHit),
    .secondaryAddrHit(secondaryAddrHit), .primaryRangeActive(primaryRangeActive),
    .secondaryRangeActive(secondaryRangeActive), .primarySerialRun(primarySerialRun),
    .secondarySerialRun(secondarySerialRun), .enhancedFloppyMode2(enhancedFloppyMode2),
    .floppyIfMode(floppyIfMode), .powerGoodInput(powerGoodInput), .gameSelReq(gameSelReq),
    .chipPowerGood(chipPowerGood), .gamePortSelectOutN(gamePortSelectOutN),
    .gamePortSelectOeN(gamePortSelectOeN), .densityReq(densityReq),
    .densitySelectOutB(densitySelectOutB), .secondDrivePresentIn(secondDrivePresentIn),
    .extraAddrReq(extraAddrReq), .auxIrqReq(auxIrqReq),
    .secondDrivePresent(secondDrivePresent), .sharedPinOut(sharedPinOut),
    .sharedPinOeN(sharedPinOeN)
  );

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // compare tasks, one per result kind
  task automatic checkBit(input string name, input logic exp, input logic got);
    nCompared++;
    if (got !== exp) begin
      numErrors++;
      $display("wrong value %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic checkByte(input string name, input logic [7:0] exp, input logic [7:0] got);
    nCompared++;
    if (got !== exp) begin
      numErrors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic checkMode(input string name, input cpps_fdd_mode_t exp,
                           input cpps_fdd_mode_t got);
    nCompared++;
    if (got !== exp) begin
      numErrors++;
      $display("wrong value %s expected %0d seen %0d", name, exp, got);
    end
  endtask

  task automatic giveVerdict;
    $display("comparisons %0d mismatches %0d", nCompared, numErrors);
    if (numErrors == 0 && nCompared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // configuration port cycles, entered and left at a falling edge
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic setIndex(input logic [7:0] idx, input logic mode);
    cfgMode = mode;
    idxWr   = 1'b1;
    wrData  = idx;
    cyc(1);
    idxWr   = 1'b0;
  endtask

  // index then data write; two more edges let the pin muxes follow
  task automatic regWrite(input logic [7:0] idx, input logic [7:0] val, input logic mode);
    setIndex(idx, mode);
    dataWr = 1'b1;
    wrData = val;
    cyc(1);
    dataWr  = 1'b0;
    cfgMode = 1'b0;
    cyc(2);
  endtask

  // answer stands for one cycle right after the read request edge
  task automatic regRead(input logic [7:0] idx, input logic mode, input logic [7:0] exp,
                         input string name);
    setIndex(idx, mode);
    dataRd = 1'b1;
    cyc(1);
    dataRd  = 1'b0;
    cfgMode = 1'b0;
    checkBit("rdValid", 1'b1, rdValid);
    checkByte(name, exp, rdData);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic testDefaults;
    regRead(IDX_SERIAL_POWER, 1'b1, 8'h88, "serialPower");
    regRead(IDX_PIN_FUNCTION, 1'b1, 8'hf0, "pinFunction");
    checkBit("primarySerialRun", 1'b1, primarySerialRun);
    checkBit("secondarySerialRun", 1'b1, secondarySerialRun);
    checkBit("enhancedFloppyMode2", 1'b0, enhancedFloppyMode2);
    checkMode("floppyIfMode", CPPS_FDD_AT, floppyIfMode);
    checkBit("densitySelectOutB", 1'b1, densitySelectOutB);
    checkBit("chipPowerGood", 1'b0, chipPowerGood);
    checkBit("sharedPinOeN", 1'b0, sharedPinOeN);
  endtask

  task automatic testSerialPower;
    logic [7:0] vals [4];
    vals = '{8'h08, 8'h80, 8'h00, 8'hff};
    foreach (vals[i]) begin
      regWrite(IDX_SERIAL_POWER, vals[i], 1'b1);
      checkBit("primarySerialRun", vals[i][3], primarySerialRun);
      checkBit("secondarySerialRun", vals[i][7], secondarySerialRun);
      regRead(IDX_SERIAL_POWER, 1'b1, vals[i] & 8'h88, "serialPower");
    end
  endtask

  // accesses outside configuration mode or at another index change nothing
  task automatic testRefused;
    regWrite(IDX_SERIAL_POWER, 8'h00, 1'b0);
    checkBit("primarySerialRun", 1'b1, primarySerialRun);
    regRead(IDX_SERIAL_POWER, 1'b0, 8'h00, "refusedRead");
    regWrite(8'h04, 8'h00, 1'b1);
    regRead(IDX_SERIAL_POWER, 1'b1, 8'h88, "serialPower");
    regRead(8'h04, 1'b1, 8'h00, "unmappedRead");
    // a write with the clock enable low must leave every flop frozen
    ce = 1'b0;
    regWrite(IDX_SERIAL_POWER, 8'h00, 1'b1);
    ce = 1'b1;
    checkBit("primarySerialRun", 1'b1, primarySerialRun);
    // load index 03 first so that only the mode flag can refuse the write
    regRead(IDX_PIN_FUNCTION, 1'b1, 8'hf0, "pinFunction");
    regWrite(IDX_PIN_FUNCTION, 8'h00, 1'b0);
    regRead(IDX_PIN_FUNCTION, 1'b1, 8'hf0, "pinFunction");
  endtask

  // every mode code and pin choice; inputs: power good 0, game req 1, density 0,
  // drive present 1, extra address 1, aux interrupt 0
  task automatic testPinFunction;
    logic [7:0] vals [6];
    vals = '{8'h00, 8'h23, 8'h46, 8'h84, 8'h9f, 8'hf0};
    foreach (vals[i]) begin
      regWrite(IDX_PIN_FUNCTION, vals[i], 1'b1);
      regRead(IDX_PIN_FUNCTION, 1'b1, vals[i] & 8'hf7, "pinFunction");
      checkBit("enhancedFloppyMode2", vals[i][1], enhancedFloppyMode2);
      checkBit("densitySelectOutB", vals[i][4], densitySelectOutB);
      checkMode("floppyIfMode", cpps_fdd_mode_t'(vals[i][6:5]), floppyIfMode);
      checkBit("chipPowerGood", vals[i][0], chipPowerGood);
      checkBit("gamePortSelectOutN", ~vals[i][0], gamePortSelectOutN);
      checkBit("gamePortSelectOeN", ~vals[i][0], gamePortSelectOeN);
      checkBit("secondDrivePresent", ~vals[i][7], secondDrivePresent);
      checkBit("sharedPinOeN", ~vals[i][7], sharedPinOeN);
      checkBit("sharedPinOut", vals[i][7] & ~vals[i][2], sharedPinOut);
    end
    // flipped inputs tell the pass-through paths from constant levels
    {powerGoodInput, densityReq, auxIrqReq} = 3'b111;
    regWrite(IDX_PIN_FUNCTION, 8'h84, 1'b1);
    checkBit("chipPowerGood", 1'b1, chipPowerGood);
    checkBit("densitySelectOutB", 1'b1, densitySelectOutB);
    checkBit("sharedPinOut", 1'b1, sharedPinOut);
    {powerGoodInput, densityReq, auxIrqReq} = 3'b000;
  endtask

  // decode keeps running with the primary port powered down
  task automatic testDecode;
    regWrite(IDX_SERIAL_POWER, 8'h80, 1'b1);
    primaryBase   = 16'h03f8;
    secondaryBase = 16'h00f8;
    hostAddr      = 16'h03ff;
    cyc(2);
    checkBit("primaryAddrHit", 1'b1, primaryAddrHit);
    checkBit("primaryRangeActive", 1'b1, primaryRangeActive);
    checkBit("secondaryRangeActive", 1'b0, secondaryRangeActive);
    hostAddr = 16'h00fa;
    cyc(2);
    checkBit("secondaryAddrHit", 1'b0, secondaryAddrHit);
    checkBit("primaryAddrHit", 1'b0, primaryAddrHit);
    secondaryBase = 16'h0100;
    hostAddr      = 16'h0107;
    cyc(2);
    checkBit("secondaryAddrHit", 1'b1, secondaryAddrHit);
    hostAddr = 16'h0108;
    cyc(2);
    checkBit("secondaryAddrHit", 1'b0, secondaryAddrHit);
  endtask

  // hardware reset leaves the registers; a second power-up reset restores them
  task automatic testResets;
    regWrite(IDX_SERIAL_POWER, 8'h08, 1'b1);
    regWrite(IDX_PIN_FUNCTION, 8'h02, 1'b1);
    hostReset = 1'b1;
    cyc(2);
    hostReset = 1'b0;
    cyc(1);
    checkBit("secondarySerialRun", 1'b0, secondarySerialRun);
    regRead(IDX_SERIAL_POWER, 1'b1, 8'h08, "serialPower");
    regRead(IDX_PIN_FUNCTION, 1'b1, 8'h02, "pinFunction");
    sysRst = 1'b1;
    cyc(2);
    sysRst = 1'b0;
    cyc(2);
    testDefaults();
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {hostReset, cfgMode, idxWr, dataWr, dataRd, powerGoodInput} = '0;
    {densityReq, auxIrqReq} = '0;
    {ce, gameSelReq, secondDrivePresentIn, extraAddrReq, sysRst} = '1;
    wrData = 8'h00;
    hostAddr = 16'h0000;
    primaryBase = 16'h0000;
    secondaryBase = 16'h0000;
    numErrors = 0;
    nCompared = 0;
    cyc(16);
    sysRst = 1'b0;
    cyc(2);
    testDefaults();
    testSerialPower();
    testRefused();
    testPinFunction();
    testDecode();
    testResets();
    giveVerdict();
  end

  // watchdog, far beyond the some 150 cycles the scenarios need
  initial begin
    repeat (20000) @(posedge clk);
    numErrors++;
    giveVerdict();
  end
endmodule
